// [dqr_pkg.sv]
// Purpose: shared constants for the acquisition card register interface
// Assumes: one 10 MHz clock, word-indexed register port
// Notes:   every offset, field position and reset value lives here
package dqr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int SAMPLE_W = 16;                       // conversion sample width
  localparam int CHAN_W   = 5;                        // channel number width
  localparam int GAIN_W   = 2;                        // gain code width
  localparam int PORT_W   = 16;                       // isolated port width
  localparam int ADDR_W   = 3;                        // register index width
  localparam int DATA_W   = 32;                       // host data width
  localparam int FIFO_DEPTH = 4;                      // sample buffer depth

  ////////////////////////////////////////////////////////////////////////////
  // register indexes
  localparam logic [ADDR_W-1:0] REG_SAMPLE     = 3'h0; // 16-bit result, pops
  localparam logic [ADDR_W-1:0] REG_SAMPLE_TAG = 3'h1; // result plus channel, pops
  localparam logic [ADDR_W-1:0] REG_CHAN       = 3'h2; // channel select
  localparam logic [ADDR_W-1:0] REG_GAIN       = 3'h3; // gain range code
  localparam logic [ADDR_W-1:0] REG_OUT_PORT   = 3'h4; // isolated output port
  localparam logic [ADDR_W-1:0] REG_IN_PORT    = 3'h5; // isolated input port
  localparam logic [ADDR_W-1:0] REG_CTRL       = 3'h6; // mode, flush, soft reset

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int TAG_LSB        = 16;                 // channel tag low bit
  localparam int CTRL_AUTOSCAN  = 0;                  // auto-scan enable
  localparam int CTRL_FLUSH     = 1;                  // write 1: empty buffer
  localparam int CTRL_SOFT_RST  = 2;                  // write 1: port config reset
  localparam int STAT_EMPTY     = 1;                  // read: buffer empty
  localparam int STAT_FULL      = 2;                  // read: buffer full

  ////////////////////////////////////////////////////////////////////////////
  // gain codes, code zero is unity
  typedef enum logic [GAIN_W-1:0] {
    DQR_GAIN_X1,                                      // x1 on both variants
    DQR_GAIN_STEP1,                                   // x10 high, x2 normal
    DQR_GAIN_STEP2,                                   // x100 high, x4 normal
    DQR_GAIN_STEP3                                    // x1000 high, x8 normal
  } dqr_gain_t;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;   // channel zero
  localparam logic [PORT_W-1:0] PORT_RESET = 16'h0000; // outputs off
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000; // idle read data

endpackage : dqr_pkg

// [dqr_regs.sv]
// Function
// - sample register returns sixteen-bit result, bit0 LSB
// - tagged word: sample low, channel bits 16-20
// - channel select holds values 0 through 31
// - channel is fixed channel or scan end
// - gain resets to unity
// - four gain settings per variant
// - output port drives written word bits
// - input port read returns live pins
// - soft reset restores port configuration and empties the sample buffer
// - repeated data reads drain successive samples
// - samples pass as two's complement unchanged
// - host flush discards all buffered samples
//
// Purpose: host register interface of a multifunction acquisition card
// Assumes: inputs synchronous to sys_clk; converter hands samples valid/ready
// Notes:   holds the sample buffer and the register block in one file
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// sample buffer: flip-flop fifo with valid/ready on both sides
module dqr_fifo #(
  parameter int WIDTH = 21,                           // word width
  parameter int DEPTH = 4                             // entries, power of two
) (
  input  wire logic             clk,                  // clock
  input  wire logic             rst_n,                // synced reset, low
  input  wire logic             flush,                // discard everything
  input  wire logic             in_valid,             // writer has a word
  output logic                  in_ready,             // room for a word
  input  wire logic [WIDTH-1:0] in_data,              // word to store
  output logic                  out_valid,            // word available
  input  wire logic             out_ready,            // reader takes word
  output logic      [WIDTH-1:0] out_data              // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dqr_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;                 // storage
    logic [AW-1:0]               wp;                  // write pointer
    logic [AW-1:0]               rp;                  // read pointer
    logic [AW:0]                 cnt;                 // words held
  } dqr_fifo_state_t;

  dqr_fifo_state_t st;                                // present state
  dqr_fifo_state_t next_st;                           // next state
  logic            push;                              // word accepted
  logic            pop;                               // word delivered

  // handshakes straight from the count
  assign in_ready  = (st.cnt != DEPTH[AW:0]);
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state
  always_comb begin
    next_st = st;
    if (flush) begin                                  // flush beats push and pop
      next_st.wp  = '0;
      next_st.rp  = '0;
      next_st.cnt = '0;
    end else begin
      if (push) begin                                 // store at tail
        next_st.mem[st.wp] = in_data;
        next_st.wp         = st.wp + 1'b1;
      end
      if (pop) begin                                  // advance head
        next_st.rp = st.rp + 1'b1;
      end
      case ({push, pop})
        2'b10:   next_st.cnt = st.cnt + 1'b1;         // grew
        2'b01:   next_st.cnt = st.cnt - 1'b1;         // shrank
        default: next_st.cnt = st.cnt;                // unchanged
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : dqr_fifo // dqr_fifo

////////////////////////////////////////////////////////////////////////////////
// register block top
module dqr_regs #(
  parameter int FIFO_DEPTH = dqr_pkg::FIFO_DEPTH      // sample buffer depth
) (
  input  wire logic                          sys_clk,      // 10 MHz clock
  input  wire logic                          rst_b,        // async reset, low
  input  wire logic [dqr_pkg::ADDR_W-1:0]    host_addr,    // register index
  input  wire logic                          host_wr,      // write strobe
  input  wire logic [dqr_pkg::DATA_W-1:0]    host_wdata,   // write data
  input  wire logic                          host_rd,      // read strobe
  output logic      [dqr_pkg::DATA_W-1:0]    host_rdata,   // read data
  output logic                               host_rvalid,  // read data pulse
  input  wire logic                          sample_valid, // converter result ready
  output logic                               sample_ready, // buffer takes result
  input  wire logic [dqr_pkg::SAMPLE_W-1:0]  sample_data,  // two's complement result
  output logic      [dqr_pkg::CHAN_W-1:0]    conv_channel, // channel to convert
  output logic      [dqr_pkg::GAIN_W-1:0]    gain_range_code, // gain to front end
  output logic      [dqr_pkg::PORT_W-1:0]    output_port_word, // isolated outputs
  input  wire logic [dqr_pkg::PORT_W-1:0]    input_port_word   // isolated inputs
);
  localparam int TAG_W = dqr_pkg::SAMPLE_W + dqr_pkg::CHAN_W; // buffered word

  // the tag must land inside the host word
  if (dqr_pkg::TAG_LSB + dqr_pkg::CHAN_W > dqr_pkg::DATA_W) begin : g_bad_tag
    $error("dqr_regs: channel tag does not fit host word");
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_b;                                   // first stage
  logic rst_sync_b;                                   // released copy

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [dqr_pkg::CHAN_W-1:0] chan_sel;             // fixed or ending channel
    dqr_pkg::dqr_gain_t         gain;                 // gain code
    logic [dqr_pkg::PORT_W-1:0] out_word;             // output port latch
    logic                       autoscan;             // scan mode on
    logic [dqr_pkg::CHAN_W-1:0] scan_ch;              // channel now scanned
    logic [dqr_pkg::DATA_W-1:0] rdata;                // read data register
    logic                       rvalid;               // read answer pulse
  } dqr_regs_state_t;

  dqr_regs_state_t st;                                // present state
  dqr_regs_state_t next_st;                           // next state

  logic             wr_ctrl;                          // control write
  logic             soft_rst;                         // port config reset
  logic             flush;                            // buffer discard
  logic             data_rd;                          // read of a data register
  logic             buf_valid;                        // buffer not empty
  logic             buf_in_ready;                     // buffer not full
  logic [TAG_W-1:0] buf_word;                         // oldest buffered word
  logic             sample_take;                      // result accepted

  // decode of strobes
  assign wr_ctrl  = host_wr && (host_addr == dqr_pkg::REG_CTRL);
  assign soft_rst = wr_ctrl && host_wdata[dqr_pkg::CTRL_SOFT_RST];
  assign flush    = wr_ctrl && (host_wdata[dqr_pkg::CTRL_FLUSH]
                                || host_wdata[dqr_pkg::CTRL_SOFT_RST]);
  assign data_rd  = host_rd && ((host_addr == dqr_pkg::REG_SAMPLE)
                                || (host_addr == dqr_pkg::REG_SAMPLE_TAG));

  //////////////////////////////////////////////////////////////////////////////
  // sample buffer; a data read pops one word
  dqr_fifo #(
    .WIDTH (TAG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_sync_b),
    .flush     (flush),
    .in_valid  (sample_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({conv_channel, sample_data}),         // tag rides with sample
    .out_valid (buf_valid),
    .out_ready (data_rd),
    .out_data  (buf_word)
  );

  // back-pressure reaches the converter; stalled during a flush
  assign sample_ready = buf_in_ready && !flush;
  assign sample_take  = sample_valid && sample_ready;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st        = st;
    next_st.rvalid = host_rd;                         // answer one cycle later

    // host writes
    if (host_wr) begin
      unique case (host_addr)
        dqr_pkg::REG_CHAN: begin                      // 5-bit field, 0..31
          next_st.chan_sel = host_wdata[dqr_pkg::CHAN_W-1:0];
          next_st.scan_ch  = dqr_pkg::CHAN_RESET;     // restart scan
        end
        dqr_pkg::REG_GAIN: begin                      // two-bit code
          next_st.gain = dqr_pkg::dqr_gain_t'(host_wdata[dqr_pkg::GAIN_W-1:0]);
        end
        dqr_pkg::REG_OUT_PORT: begin                  // drive outputs
          next_st.out_word = host_wdata[dqr_pkg::PORT_W-1:0];
        end
        dqr_pkg::REG_CTRL: begin                      // mode bit
          next_st.autoscan = host_wdata[dqr_pkg::CTRL_AUTOSCAN];
          next_st.scan_ch  = dqr_pkg::CHAN_RESET;
        end
        default: begin                                // read-only or unmapped
        end
      endcase
    end

    // scan pointer walks 0..end then wraps
    if (sample_take && st.autoscan && !(host_wr && (host_addr == dqr_pkg::REG_CHAN || wr_ctrl))) begin
      if (st.scan_ch >= st.chan_sel) begin
        next_st.scan_ch = dqr_pkg::CHAN_RESET;
      end else begin
        next_st.scan_ch = st.scan_ch + 1'b1;
      end
    end

    // soft reset: port config here, buffer emptied through flush; gain and bus side kept
    if (soft_rst) begin
      next_st.chan_sel = dqr_pkg::CHAN_RESET;
      next_st.out_word = dqr_pkg::PORT_RESET;
      next_st.autoscan = 1'b0;
      next_st.scan_ch  = dqr_pkg::CHAN_RESET;
    end

    // host reads
    next_st.rdata = dqr_pkg::DATA_ZERO;
    if (host_rd) begin
      unique case (host_addr)
        dqr_pkg::REG_SAMPLE: begin                    // bit0 LSB, bit15 MSB
          if (buf_valid) begin
            next_st.rdata[dqr_pkg::SAMPLE_W-1:0] = buf_word[dqr_pkg::SAMPLE_W-1:0];
          end
        end
        dqr_pkg::REG_SAMPLE_TAG: begin                // sample plus channel
          if (buf_valid) begin
            next_st.rdata[dqr_pkg::SAMPLE_W-1:0] = buf_word[dqr_pkg::SAMPLE_W-1:0];
            next_st.rdata[dqr_pkg::TAG_LSB +: dqr_pkg::CHAN_W] =
              buf_word[dqr_pkg::SAMPLE_W +: dqr_pkg::CHAN_W];
          end
        end
        dqr_pkg::REG_CHAN: begin                      // channel readback
          next_st.rdata[dqr_pkg::CHAN_W-1:0] = st.chan_sel;
        end
        dqr_pkg::REG_GAIN: begin                      // gain readback
          next_st.rdata[dqr_pkg::GAIN_W-1:0] = st.gain;
        end
        dqr_pkg::REG_OUT_PORT: begin                  // output latch readback
          next_st.rdata[dqr_pkg::PORT_W-1:0] = st.out_word;
        end
        dqr_pkg::REG_IN_PORT: begin                   // live pins, no latch
          next_st.rdata[dqr_pkg::PORT_W-1:0] = input_port_word;
        end
        dqr_pkg::REG_CTRL: begin                      // mode and buffer state
          next_st.rdata[dqr_pkg::CTRL_AUTOSCAN] = st.autoscan;
          next_st.rdata[dqr_pkg::STAT_EMPTY]    = !buf_valid;
          next_st.rdata[dqr_pkg::STAT_FULL]     = !buf_in_ready;
        end
        default: begin                                // unmapped reads zero
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; gain comes up unity
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st.chan_sel <= dqr_pkg::CHAN_RESET;
      st.gain     <= dqr_pkg::DQR_GAIN_X1;
      st.out_word <= dqr_pkg::PORT_RESET;
      st.autoscan <= 1'b0;
      st.scan_ch  <= dqr_pkg::CHAN_RESET;
      st.rdata    <= dqr_pkg::DATA_ZERO;
      st.rvalid   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign conv_channel     = st.autoscan ? st.scan_ch : st.chan_sel;
  assign gain_range_code  = st.gain;
  assign output_port_word = st.out_word;
  assign host_rdata       = st.rdata;
  assign host_rvalid      = st.rvalid;

endmodule : dqr_regs // dqr_regs

// [dqr_conv_model.sv]
// Purpose: converter stand-in that offers samples over valid/ready
// Assumes: bench hands words in by load pulses; offered in order
// Notes:   an idle data line toggles each cycle between the last word and its inverse
`timescale 1ns/1ps
module dqr_conv_model (
  input  wire logic        clk,          // system clock
  input  wire logic        rst_n,        // reset, low
  input  wire logic        load,         // bench hands a word
  input  wire logic [15:0] load_data,    // word to queue
  input  wire logic        sample_ready, // buffer takes word
  output logic             sample_valid, // word on offer
  output logic      [15:0] sample_data   // offered word
);
  logic [15:0] pend[$];                  // words not yet taken
  logic        taken;                    // handshake at this edge
  logic        ld_now;                   // load seen at this edge
  logic [15:0] ld_word;                  // word seen at this edge

  ////////////////////////////////////////////////////////////////////////////
  // offer holds until taken; sample at the edge, change just after it
  initial begin
    sample_valid = 1'b0;
    sample_data  = 16'h0000;
  end
  always @(posedge clk) begin
    taken   = sample_valid && sample_ready;
    ld_now  = load;
    ld_word = load_data;
    #1;
    if (!rst_n) begin                    // reset drops everything
      pend.delete();
    end else begin
      if (taken) begin                   // move to next word
        void'(pend.pop_front());
      end
      if (ld_now) begin
        pend.push_back(ld_word);
      end
    end
    sample_valid = (pend.size() > 0);
    sample_data  = (pend.size() > 0) ? pend[0] : ~sample_data;
  end
endmodule // dqr_conv_model

// [dqr_regs_props.sv]
// Purpose: port assertions for the acquisition card register block
// Assumes: sees only the top ports; one clock domain
// Notes:   bound into every dqr_regs instance at the foot
`timescale 1ns/1ps
module dqr_regs_props #(
  parameter int FIFO_DEPTH = dqr_pkg::FIFO_DEPTH   // buffer depth
) (
  input wire logic                         sys_clk,          // clock
  input wire logic                         rst_b,            // reset, low
  input wire logic [dqr_pkg::ADDR_W-1:0]   host_addr,        // index
  input wire logic                         host_wr,          // write
  input wire logic [dqr_pkg::DATA_W-1:0]   host_wdata,       // wdata
  input wire logic                         host_rd,          // read
  input wire logic [dqr_pkg::DATA_W-1:0]   host_rdata,       // rdata
  input wire logic                         host_rvalid,      // answer
  input wire logic                         sample_ready,     // buffer takes
  input wire logic [dqr_pkg::CHAN_W-1:0]   conv_channel,     // channel
  input wire logic [dqr_pkg::GAIN_W-1:0]   gain_range_code,  // gain
  input wire logic [dqr_pkg::PORT_W-1:0]   output_port_word, // outputs
  input wire logic [dqr_pkg::PORT_W-1:0]   input_port_word   // inputs
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // read answers, one cycle after the strobe and idle otherwise
  a_read_answer: assert property (host_rd |=> host_rvalid)
    else $error("read not answered next cycle");
  a_no_stray: assert property (!host_rd |=> !host_rvalid && host_rdata == 32'h0000_0000)
    else $error("read data outside an answer");
  a_sample_width: assert property (host_rd && host_addr == dqr_pkg::REG_SAMPLE |=> host_rdata[31:16] == 16'h0000)
    else $error("sample word wider than sixteen bits");
  a_tag_field: assert property (host_rd && host_addr == dqr_pkg::REG_SAMPLE_TAG |=> host_rdata[31:21] == 11'h000)
    else $error("tagged word above bit twenty");
  a_in_live: assert property (host_rd && host_addr == dqr_pkg::REG_IN_PORT
    |=> host_rdata == {16'h0000, $past(input_port_word)})
    else $error("input port read not live");
  // output port follows its writes and soft reset; gain follows its writes and nothing else
  a_out_write: assert property (host_wr && host_addr == dqr_pkg::REG_OUT_PORT
    |=> output_port_word == $past(host_wdata[15:0]))
    else $error("output port missed a write");
  a_out_hold: assert property (!(host_wr && (host_addr == dqr_pkg::REG_OUT_PORT || host_addr == dqr_pkg::REG_CTRL))
    |=> $stable(output_port_word))
    else $error("output port changed unasked");
  a_gain_write: assert property (host_wr && host_addr == dqr_pkg::REG_GAIN
    |=> gain_range_code == $past(host_wdata[1:0]))
    else $error("gain code missed a write");
  a_gain_hold: assert property (!(host_wr && host_addr == dqr_pkg::REG_GAIN) |=> $stable(gain_range_code))
    else $error("gain code changed unasked");
  // flush and soft reset
  a_flush_refuse: assert property (host_wr && host_addr == dqr_pkg::REG_CTRL && host_wdata[1] |-> !sample_ready)
    else $error("sample taken during flush");
  a_soft_clear: assert property (host_wr && host_addr == dqr_pkg::REG_CTRL && host_wdata[2]
    |=> output_port_word == 16'h0000 && conv_channel == 5'h00)
    else $error("soft reset left port state");
endmodule // dqr_regs_props

bind dqr_regs dqr_regs_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_dqr_regs_props (.sys_clk, .rst_b, .host_addr, .host_wr,
  .host_wdata, .host_rd, .host_rdata, .host_rvalid, .sample_ready, .conv_channel, .gain_range_code,
  .output_port_word, .input_port_word);

// [tb.sv]
// Purpose: self-checking bench for the acquisition card register block
// Assumes: strobes one cycle wide, driven 1 ns after the rising edge
// Notes:   expected samples and tags kept in a queue beside the design
`timescale 1ns/1ps
module tb;
  logic        sys_clk;               // 10 MHz clock
  logic        rst_b;                 // reset, low
  logic [2:0]  host_addr;             // register index
  logic        host_wr;               // write strobe
  logic        host_rd;               // read strobe
  logic [31:0] host_wdata;            // write data
  logic [31:0] host_rdata;            // read data
  logic        host_rvalid;           // read answer
  logic        sample_valid;          // offered sample
  logic        sample_ready;          // buffer takes
  logic [15:0] sample_data;           // sample word
  logic [4:0]  conv_channel;          // channel in use
  logic [1:0]  gain_range_code;       // gain to front end
  logic [15:0] output_port_word;      // isolated outputs
  logic [15:0] input_port_word;       // isolated inputs
  logic        load;                  // model gets a word
  logic [15:0] load_data;             // word for the model
  logic [31:0] rnd;                   // lfsr state
  logic [20:0] exp_q[$];              // expected tag and sample
  int          mismatches = 0;        // failed compares
  int          cmp_count = 0;         // compares made
  int          chan_reg = 0;          // modelled channel select
  int          scan_ptr = 0;          // modelled scan position
  bit          autoscan = 0;          // modelled scan mode

  dqr_regs #(.FIFO_DEPTH(4)) i_dqr_regs (.sys_clk, .rst_b, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata,
    .host_rvalid, .sample_valid, .sample_ready, .sample_data, .conv_channel, .gain_range_code, .output_port_word,
    .input_port_word);
  dqr_conv_model i_dqr_conv_model (.clk(sys_clk), .rst_n(rst_b), .load, .load_data, .sample_ready, .sample_valid,
    .sample_data);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask
  // one write pulse, then update the bench model
  task automatic wr(logic [2:0] a, logic [31:0] d);
    @(posedge sys_clk) #1;
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge sys_clk) #1;
    host_wr = 1'b0;
    if (a == dqr_pkg::REG_CHAN) begin
      chan_reg = d[4:0];
      scan_ptr = 0;
    end
    if (a == dqr_pkg::REG_CTRL) begin
      autoscan = d[0];
      scan_ptr = 0;
      if (d[1] | d[2]) exp_q.delete();
      if (d[2]) chan_reg = 0;
    end
  endtask
  // one read pulse, answer looked at in its single cycle
  task automatic rd(logic [2:0] a, logic [31:0] exp);
    @(posedge sys_clk) #1;
    host_rd = 1'b1;
    host_addr = a;
    @(posedge sys_clk) #1;
    host_rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, host_rvalid});
    chk("rdata", exp, host_rdata);
  endtask
  // data read, expected oldest sample or zero when empty
  task automatic pop(logic [2:0] a);
    logic [20:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 21'h0;
    rd(a, (a == dqr_pkg::REG_SAMPLE) ? {16'h0000, e[15:0]} : {11'h000, e});
  endtask
  // hand a word to the converter model with its expected tag
  task automatic ld(logic [15:0] d);
    exp_q.push_back({autoscan ? scan_ptr[4:0] : chan_reg[4:0], d});
    if (autoscan) scan_ptr = (scan_ptr >= chan_reg) ? 0 : scan_ptr + 1;
    @(posedge sys_clk) #1;
    load = 1'b1;
    load_data = d;
    @(posedge sys_clk) #1;
    load = 1'b0;
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_b, host_wr, host_rd, load} = 4'h0;
    host_addr = 3'h0;
    host_wdata = 32'h0000_0000;
    load_data = 16'h0000;
    input_port_word = 16'h0000;
    rnd = 32'h892d192b;
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("gain", 32'h0, {30'h0, gain_range_code});
    rd(dqr_pkg::REG_GAIN, 32'h0);
    rd(dqr_pkg::REG_CTRL, 32'h2);
    rd(3'h7, 32'h0);
    for (int g = 0; g < 4; g++) begin // every gain code
      wr(dqr_pkg::REG_GAIN, g);
      chk("gain", g, {30'h0, gain_range_code});
      rd(dqr_pkg::REG_GAIN, g);
    end
    for (int i = 0; i < 4; i++) begin // random port words
      rnd = lfsr(rnd);
      wr(dqr_pkg::REG_OUT_PORT, rnd);
      chk("outport", rnd[15:0], {16'h0, output_port_word});
      rd(dqr_pkg::REG_OUT_PORT, {16'h0, rnd[15:0]});
      input_port_word = rnd[31:16];
      rd(dqr_pkg::REG_IN_PORT, {16'h0, rnd[31:16]});
    end
    // fill past the buffer, then drain alternating both data views
    wr(dqr_pkg::REG_CHAN, rnd[4:0]);
    chk("channel", rnd[4:0], {27'h0, conv_channel});
    ld(16'h7fff);
    ld(16'h8000);
    ld(rnd[15:0]);
    ld(~rnd[15:0]);
    ld(16'h0001);
    repeat (2) @(posedge sys_clk);
    chk("ready", 32'h0, {31'h0, sample_ready});
    rd(dqr_pkg::REG_CTRL, 32'h4);
    for (int k = 0; k < 6; k++) pop(k[0] ? dqr_pkg::REG_SAMPLE_TAG : dqr_pkg::REG_SAMPLE);
    // auto-scan ending at channel two
    wr(dqr_pkg::REG_CTRL, 32'h1);
    wr(dqr_pkg::REG_CHAN, 32'h2);
    chk("channel", 32'h0, {27'h0, conv_channel});
    for (int k = 0; k < 4; k++) ld(16'(lfsr(rnd + k)));
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) pop(dqr_pkg::REG_SAMPLE_TAG);
    // flush discards what is stored
    ld(16'h1234);
    ld(16'h4321);
    repeat (2) @(posedge sys_clk);
    wr(dqr_pkg::REG_CTRL, 32'h3);
    rd(dqr_pkg::REG_CTRL, 32'h3);
    pop(dqr_pkg::REG_SAMPLE);
    // soft reset clears port setup but keeps the gain
    wr(dqr_pkg::REG_OUT_PORT, 32'ha5c3);
    wr(dqr_pkg::REG_CHAN, 32'h9);
    wr(dqr_pkg::REG_GAIN, 32'h2);
    ld(16'h5a5a);
    repeat (2) @(posedge sys_clk);
    wr(dqr_pkg::REG_CTRL, 32'h4);
    chk("outport", 32'h0, {16'h0, output_port_word});
    chk("gain", 32'h2, {30'h0, gain_range_code});
    rd(dqr_pkg::REG_CHAN, 32'h0);
    rd(dqr_pkg::REG_CTRL, 32'h2);
    // a write to the read-only input index changes nothing
    wr(dqr_pkg::REG_IN_PORT, 32'hffff_ffff);
    chk("outport", 32'h0, {16'h0, output_port_word});
    rd(dqr_pkg::REG_IN_PORT, {16'h0, rnd[31:16]});
    wrap_up();
  end
endmodule // tb
